// ---- design/cspr_map.svh ----
// Behaviour
// - reset held one millisecond after supply-ok rises
// - keep supply-ok high during boundary scan
// - bus owner drives command over two cycles
// - reset held 1 us warm, 1 ms power-on
// - reset invalidates caches without any writeback
// - agents release bus outputs within two clocks
// - latch config at reset release, maybe self-test
// - fetch starts at configured reset vector
// - request parity over strobe and command lines
// - response parity beside status, idle reads high
// - decode connector occupancy with voltage code
// - sleep request in grant state enters sleep
// - sleep exits to grant on request release
// - clock-stop issues acknowledge, gates core clocks
// - clock-stop release restarts all clocks, resumes
// - management interrupt saves, acknowledges, runs handler
// - thermal trip halts and latches shutdown output
// - trip still present at reset keeps halt
// - test reset held low through power-on reset
// - target-ready only when write data acceptable
// - sideband change rides with write target-ready
`ifndef CSPR_MAP_SVH
`define CSPR_MAP_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CSPR_CLK_NS           100
`define CSPR_POR_HOLD_MS      1
`define CSPR_WARM_HOLD_US     1
`define CSPR_POR_CYCLES       ((`CSPR_POR_HOLD_MS * 1000000 + `CSPR_CLK_NS - 1) / `CSPR_CLK_NS)
`define CSPR_WARM_CYCLES      ((`CSPR_WARM_HOLD_US * 1000 + `CSPR_CLK_NS - 1) / `CSPR_CLK_NS)
`define CSPR_BUS_RELEASE_CLKS 2
`define CSPR_BUILTIN_SELF_TEST_CYCLES      8'h20

// ----------------------------------------------------------------
// values and field positions
// ----------------------------------------------------------------
`define CSPR_RESET_VECTOR     32'h0FFF_FFF0
`define CSPR_VID_DEFAULT      5'h0A
`define CSPR_VID_TERMINATOR   5'h1F
`define CSPR_RS_IDLE_N        3'h7
`define CSPR_RS_DEFAULT       3'h1
`define CSPR_CMD_WR_BIT       0
`define CSPR_CMD_STOP_ACK     10'h0_22
`define CSPR_CMD_SMI_ACK      10'h0_42
`define CSPR_SB_SUPPLY        0
`define CSPR_SB_SLEEP         1
`define CSPR_SB_STOP          2
`define CSPR_SB_SMI           3
`define CSPR_SB_INIT          4

`endif

// ---- design/cspr_pkg.sv ----
`default_nettype none
package cspr_pkg;

  typedef enum logic [3:0] {
    ST_RESET   = 4'h0,
    ST_BUILTIN_SELF_TEST    = 4'h1,
    ST_RUN     = 4'h3,
    ST_GACK    = 4'h2,
    ST_GRANT   = 4'h6,
    ST_SLEEP   = 4'h7,
    ST_SMI_ACK = 4'h5,
    ST_MGMT    = 4'h4,
    ST_THERM   = 4'hC
  } cspr_dev_st_e;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_A    = 2'h1,
    SEQ_B    = 2'h3,
    SEQ_WAIT = 2'h2
  } cspr_seq_e;

  typedef enum logic [1:0] {
    SLOT_EMPTY = 2'h0,
    SLOT_TERM  = 2'h1,
    SLOT_CPU   = 2'h2
  } cspr_slot_e;

  typedef struct packed {
    logic [4:0]   s1;
    logic [4:0]   s2;
    logic         rst_prev;
    logic         smi_prev;
    logic         smi_pend;
    cspr_dev_st_e st;
    cspr_seq_e    seq;
    logic [9:0]   cmd;
    logic         ack_sent;
    logic         ads_o;
    logic [4:0]   req_o;
    logic         rp_o;
    logic         oe_n;
    logic         cfg_float;
    logic [7:0]   builtin_self_test_cnt;
    logic         therm;
    logic         resp_v;
    logic [2:0]   resp_st;
    logic         resp_perr;
    logic         wr_go;
    logic         save;
    logic         fetch;
    logic [31:0]  vec;
    logic         inval;
  } cspr_dev_s;

  typedef struct packed {
    logic         pg1;
    logic         pg2;
    logic [5:0]   occ1;
    logic [5:0]   occ2;
    logic [13:0]  cnt;
    logic         rst_n;
    logic         por;
    logic         sup;
    logic [4:0]   sb_n;
    logic         wr_open;
    logic         rx;
    logic [4:0]   half;
    logic         perr_acc;
    logic         cmd_v;
    logic [9:0]   cmd;
    logic         perr;
    logic         target_ready_in;
    logic         rs_drv;
    logic [2:0]   rs_val;
    cspr_slot_e   slot;
  } cspr_sys_s;

  // high when an even count of low-true pins is low
  function automatic logic cspr_lowpar(input logic [5:0] pins);
    return ~(^(~pins));
  endfunction : cspr_lowpar

endpackage : cspr_pkg
`default_nettype wire

// ---- design/cspr_if.sv ----
`default_nettype none
interface cspr_if;
  logic       bus_reset_n;
  logic       supply_ok_input;
  logic       sleep_request_n;
  logic       clock_stop_request_n;
  logic       mgmt_interrupt_in_n;
  logic       soft_init_n;
  logic       float_cfg_n;
  logic       thermal_shutdown_out_n;
  logic       connector_occupied_n;
  logic [4:0] voltage_id_code;
  logic       dev_ads_o;
  logic [4:0] dev_req_o;
  logic       dev_rp_o;
  logic       dev_req_oe_n;
  logic [2:0] sys_rs_o;
  logic       sys_rsp_o;
  logic       sys_rs_oe_n;
  logic       sys_target_ready_in_o;
  logic       sys_target_ready_in_oe_n;
  logic       address_strobe_n;
  logic [4:0] request_cmd_n;
  logic       request_parity_n;
  logic [2:0] response_status_lines_n;
  logic       response_parity_n;
  logic       target_ready_in_n;

  // released lines float high through the bus termination
  assign address_strobe_n        = dev_req_oe_n ? 1'b1 : dev_ads_o;
  assign request_cmd_n           = dev_req_oe_n ? 5'h1F : dev_req_o;
  assign request_parity_n        = dev_req_oe_n ? 1'b1 : dev_rp_o;
  assign response_status_lines_n = sys_rs_oe_n ? 3'h7 : sys_rs_o;
  assign response_parity_n       = sys_rs_oe_n ? 1'b1 : sys_rsp_o;
  assign target_ready_in_n       = sys_target_ready_in_oe_n ? 1'b1 : sys_target_ready_in_o;

  modport dev (
    input  bus_reset_n, supply_ok_input, sleep_request_n, clock_stop_request_n,
    input  mgmt_interrupt_in_n, soft_init_n, float_cfg_n,
    input  response_status_lines_n, response_parity_n, target_ready_in_n,
    output thermal_shutdown_out_n, connector_occupied_n, voltage_id_code,
    output dev_ads_o, dev_req_o, dev_rp_o, dev_req_oe_n
  );
  modport sys (
    output bus_reset_n, supply_ok_input, sleep_request_n, clock_stop_request_n,
    output mgmt_interrupt_in_n, soft_init_n, float_cfg_n,
    output sys_rs_o, sys_rsp_o, sys_rs_oe_n, sys_target_ready_in_o, sys_target_ready_in_oe_n,
    input  thermal_shutdown_out_n, connector_occupied_n, voltage_id_code,
    input  address_strobe_n, request_cmd_n, request_parity_n
  );
endinterface : cspr_if
`default_nettype wire

// ---- design/cspr_dev.sv ----
`include "cspr_map.svh"
`default_nettype none
module cspr_dev
  import cspr_pkg::*;
#(
  parameter logic [4:0] VID_CODE = `CSPR_VID_DEFAULT
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  cspr_if.dev              bus,
  input  wire logic        thermal_trip,
  input  wire logic        usr_req_valid,
  output logic             usr_req_ready,
  input  wire logic [9:0]  usr_req_cmd,
  output logic             usr_resp_valid,
  output logic [2:0]       usr_resp_status,
  output logic             usr_resp_perr,
  output logic             usr_wr_data_go,
  input  wire logic        mgmt_exit,
  output logic             management_mode,
  output logic             save_state,
  output logic             cache_invalidate,
  output logic             builtin_self_test_run,
  output logic             fetch_go,
  output logic [31:0]      fetch_addr,
  output logic             core_clk_en,
  output logic             bus_clk_en,
  output logic             snoop_en,
  output logic             intr_en,
  output logic             exec_en
);

  cspr_dev_s q;
  cspr_dev_s n;

  // ----------
  // next state
  // ----------
  always_comb begin
    logic       in_rst;
    logic       smi_edge;
    logic       done;
    logic       start;
    logic [9:0] start_cmd;
    in_rst    = 1'b0;
    smi_edge  = 1'b0;
    done      = 1'b0;
    start     = 1'b0;
    start_cmd = 10'h000;
    n = q;
    n.resp_v = 1'b0;
    n.wr_go  = 1'b0;
    n.save   = 1'b0;
    n.fetch  = 1'b0;
    n.s1 = {bus.soft_init_n, bus.mgmt_interrupt_in_n, bus.clock_stop_request_n,
            bus.sleep_request_n, bus.supply_ok_input};
    n.s2 = q.s1;
    n.smi_prev = q.s2[`CSPR_SB_SMI];
    smi_edge = q.smi_prev & ~q.s2[`CSPR_SB_SMI];
    in_rst = ~bus.bus_reset_n | ~q.s2[`CSPR_SB_SUPPLY];
    n.rst_prev = in_rst;
    // latched outside reset; follows the sensor in it
    n.therm = in_rst ? thermal_trip : (q.therm | thermal_trip);

    // two command cycles, then wait for a response
    unique case (q.seq)
      SEQ_IDLE: begin
      end
      SEQ_A: begin
        n.seq   = SEQ_B;
        n.ads_o = 1'b1;
        n.req_o = ~q.cmd[9:5];
        n.rp_o  = cspr_lowpar({1'b1, ~q.cmd[9:5]});
      end
      SEQ_B: begin
        n.seq   = SEQ_WAIT;
        n.ads_o = 1'b1;
        n.req_o = 5'h1F;
        n.rp_o  = 1'b1;
        n.oe_n  = 1'b1;
      end
      SEQ_WAIT: begin
        n.wr_go = ~bus.target_ready_in_n & q.cmd[`CSPR_CMD_WR_BIT];
        if (bus.response_status_lines_n != `CSPR_RS_IDLE_N) begin
          done        = 1'b1;
          n.seq       = SEQ_IDLE;
          n.resp_v    = 1'b1;
          n.resp_st   = ~bus.response_status_lines_n;
          n.resp_perr = bus.response_parity_n !=
                        cspr_lowpar({3'h7, bus.response_status_lines_n});
        end
      end
    endcase

    if (in_rst) begin
      n.st       = ST_RESET;
      n.ack_sent = 1'b0;
      n.smi_pend = 1'b0;
      n.inval    = 1'b1;
    end else if (q.rst_prev) begin
      // release edge: configuration caught once
      n.inval     = 1'b0;
      n.cfg_float = ~bus.float_cfg_n;
      n.vec       = `CSPR_RESET_VECTOR;
      if (bus.float_cfg_n && !q.s2[`CSPR_SB_INIT]) begin
        n.st       = ST_BUILTIN_SELF_TEST;
        n.builtin_self_test_cnt = `CSPR_BUILTIN_SELF_TEST_CYCLES;
      end else begin
        n.st    = ST_RUN;
        n.fetch = 1'b1;
      end
    end else begin
      unique case (q.st)
        ST_RESET: begin
          n.st    = ST_RUN;
          n.fetch = 1'b1;
        end
        ST_BUILTIN_SELF_TEST: begin
          if (q.builtin_self_test_cnt == 8'h00) begin
            n.st    = ST_RUN;
            n.fetch = 1'b1;
          end else begin
            n.builtin_self_test_cnt = q.builtin_self_test_cnt - 8'h01;
          end
        end
        ST_RUN: begin
          if (!q.s2[`CSPR_SB_STOP]) begin
            n.st = ST_GACK;
          end else if (q.smi_pend) begin
            n.st       = ST_SMI_ACK;
            n.save     = 1'b1;
            n.smi_pend = 1'b0;
          end else if (usr_req_valid && usr_req_ready) begin
            start     = 1'b1;
            start_cmd = usr_req_cmd;
          end
        end
        ST_GACK, ST_SMI_ACK: begin
          if (q.seq == SEQ_IDLE && !q.ack_sent) begin
            start      = 1'b1;
            start_cmd  = (q.st == ST_GACK) ? `CSPR_CMD_STOP_ACK : `CSPR_CMD_SMI_ACK;
            n.ack_sent = 1'b1;
          end
          if (done && q.ack_sent) begin
            n.ack_sent = 1'b0;
            n.st       = (q.st == ST_GACK) ? ST_GRANT : ST_MGMT;
          end
        end
        ST_GRANT: begin
          if (!q.s2[`CSPR_SB_SLEEP]) begin
            n.st = ST_SLEEP;
          end else if (q.s2[`CSPR_SB_STOP]) begin
            n.st = ST_RUN;
          end
        end
        ST_SLEEP: begin
          // only the sleep line matters here
          if (q.s2[`CSPR_SB_SLEEP]) begin
            n.st = ST_GRANT;
          end
        end
        ST_MGMT: begin
          if (mgmt_exit) begin
            n.st = ST_RUN;
          end
        end
        ST_THERM: begin
        end
        default: begin
          n.st = ST_RESET;
        end
      endcase

      if (start) begin
        n.seq   = SEQ_A;
        n.cmd   = start_cmd;
        n.ads_o = 1'b0;
        n.req_o = ~start_cmd[4:0];
        n.rp_o  = cspr_lowpar({1'b0, ~start_cmd[4:0]});
        // floated: sequence runs, pins stay released
        n.oe_n  = q.cfg_float;
      end

      // dropped in sleep; a new edge beats the clear
      if (smi_edge && q.st != ST_SLEEP) begin
        n.smi_pend = 1'b1;
      end
    end

    if (in_rst || n.therm) begin
      n.seq   = SEQ_IDLE;
      n.oe_n  = 1'b1;
      n.ads_o = 1'b1;
      n.req_o = 5'h1F;
      n.rp_o  = 1'b1;
    end
    // a trip still present at reset release keeps the halt
    if (!in_rst && n.therm) begin
      n.st    = ST_THERM;
      n.fetch = 1'b0;
    end
  end

  // ----------
  // state register
  // ----------
  always_ff @(posedge mclk) begin
    if (srst) begin
      q       <= '0;
      q.s1    <= 5'h1E;
      q.s2    <= 5'h1E;
      q.oe_n  <= 1'b1;
      q.ads_o <= 1'b1;
      q.req_o <= 5'h1F;
      q.rp_o  <= 1'b1;
      q.inval <= 1'b1;
      q.rst_prev <= 1'b1;
      q.vec   <= `CSPR_RESET_VECTOR;
    end else begin
      q <= n;
    end
  end

  // ----------
  // outputs
  // ----------
  assign bus.dev_ads_o              = q.ads_o;
  assign bus.dev_req_o              = q.req_o;
  assign bus.dev_rp_o               = q.rp_o;
  assign bus.dev_req_oe_n           = q.oe_n;
  assign bus.thermal_shutdown_out_n = ~q.therm;
  assign bus.connector_occupied_n   = 1'b0;
  assign bus.voltage_id_code        = VID_CODE;

  assign usr_req_ready    = (q.st == ST_RUN) && (q.seq == SEQ_IDLE) &&
                            q.s2[`CSPR_SB_STOP] && !q.smi_pend && !q.therm;
  assign usr_resp_valid   = q.resp_v;
  assign usr_resp_status  = q.resp_st;
  assign usr_resp_perr    = q.resp_perr;
  assign usr_wr_data_go   = q.wr_go;
  assign management_mode  = (q.st == ST_MGMT);
  assign save_state       = q.save;
  assign cache_invalidate = q.inval;
  assign builtin_self_test_run         = (q.st == ST_BUILTIN_SELF_TEST);
  assign fetch_go         = q.fetch;
  assign fetch_addr       = q.vec;
  // bus clock is gated only in sleep; the others gate internal units
  assign core_clk_en      = q.st inside {ST_RUN, ST_BUILTIN_SELF_TEST, ST_MGMT, ST_SMI_ACK, ST_GACK};
  assign bus_clk_en       = (q.st != ST_SLEEP);
  assign snoop_en         = !(q.st inside {ST_SLEEP, ST_RESET});
  assign intr_en          = !(q.st inside {ST_SLEEP, ST_RESET});
  assign exec_en          = (q.st == ST_RUN) || (q.st == ST_MGMT);

endmodule : cspr_dev
`default_nettype wire

// ---- design/cspr_sys.sv ----
`include "cspr_map.svh"
`default_nettype none
module cspr_sys
  import cspr_pkg::*;
#(
  parameter int POR_CYCLES = `CSPR_POR_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  cspr_if.sys              bus,
  input  wire logic        power_good_in,
  input  wire logic        warm_reset_req,
  input  wire logic        scan_active,
  input  wire logic        want_sleep,
  input  wire logic        want_stop,
  input  wire logic        want_smi,
  input  wire logic        want_init,
  input  wire logic        want_float,
  input  wire logic [2:0]  resp_code,
  output logic             cmd_valid,
  output logic [9:0]       cmd,
  output logic             cmd_perr,
  output cspr_slot_e       slot_state,
  output logic             test_reset_n,
  output logic             in_reset
);

  localparam logic [13:0] WARM_CNT = 14'(`CSPR_WARM_CYCLES);
  localparam logic [13:0] POR_CNT  = 14'(POR_CYCLES);

  cspr_sys_s q;
  cspr_sys_s n;

  // ----------
  // next state
  // ----------
  always_comb begin
    logic wr_ads;
    logic target_ready_in_set;
    wr_ads   = 1'b0;
    target_ready_in_set = 1'b0;
    n = q;
    n.cmd_v = 1'b0;
    n.pg1   = power_good_in;
    n.pg2   = q.pg1;
    n.occ1  = {bus.connector_occupied_n, bus.voltage_id_code};
    n.occ2  = q.occ1;

    // reset timing from the synced power-good
    if (!q.pg2) begin
      n.sup   = scan_active & q.sup;
      n.rst_n = 1'b0;
      n.por   = 1'b1;
      n.cnt   = POR_CNT;
    end else begin
      n.sup = 1'b1;
      if (!q.rst_n) begin
        if (q.cnt == 14'h0000) begin
          n.rst_n = 1'b1;
          n.por   = 1'b0;
        end else begin
          n.cnt = q.cnt - 14'h0001;
        end
      end else if (warm_reset_req) begin
        n.rst_n = 1'b0;
        n.cnt   = WARM_CNT;
      end
    end

    // request decode and response
    n.target_ready_in   = 1'b0;
    n.rs_drv = 1'b0;
    if (!q.rst_n) begin
      n.rx      = 1'b0;
      n.wr_open = 1'b0;
    end else begin
      if (!q.rx) begin
        if (!bus.address_strobe_n) begin
          n.rx       = 1'b1;
          n.half     = ~bus.request_cmd_n;
          n.perr_acc = bus.request_parity_n !=
                       cspr_lowpar({bus.address_strobe_n, bus.request_cmd_n});
          wr_ads     = ~bus.request_cmd_n[`CSPR_CMD_WR_BIT];
          n.wr_open  = wr_ads;
        end
      end else begin
        n.rx    = 1'b0;
        n.cmd_v = 1'b1;
        n.cmd   = {~bus.request_cmd_n, q.half};
        n.perr  = q.perr_acc | (bus.request_parity_n !=
                  cspr_lowpar({bus.address_strobe_n, bus.request_cmd_n}));
        n.rs_val = (resp_code == 3'h0) ? `CSPR_RS_DEFAULT : resp_code;
        if (q.half[`CSPR_CMD_WR_BIT]) begin
          // always room for data, so target-ready follows
          target_ready_in_set  = 1'b1;
          n.target_ready_in    = 1'b1;
          n.wr_open = 1'b0;
        end else begin
          n.rs_drv = 1'b1;
        end
      end
      if (q.target_ready_in) begin
        n.rs_drv = 1'b1;
      end
    end

    // sideband waits for an open write's target-ready
    if ((!q.wr_open && !wr_ads) || target_ready_in_set) begin
      n.sb_n = {~want_init, ~want_smi, ~want_stop, ~want_sleep, ~want_float};
    end

    if (q.occ2[5]) begin
      n.slot = SLOT_EMPTY;
    end else if (q.occ2[4:0] == `CSPR_VID_TERMINATOR) begin
      n.slot = SLOT_TERM;
    end else begin
      n.slot = SLOT_CPU;
    end
  end

  // ----------
  // state register
  // ----------
  always_ff @(posedge mclk) begin
    if (srst) begin
      q      <= '0;
      q.por  <= 1'b1;
      q.cnt  <= POR_CNT;
      q.sb_n <= 5'h1F;
      q.occ1 <= 6'h3F;
      q.occ2 <= 6'h3F;
    end else begin
      q <= n;
    end
  end

  // ----------
  // outputs
  // ----------
  assign bus.bus_reset_n          = q.rst_n;
  assign bus.supply_ok_input      = q.sup;
  assign bus.float_cfg_n          = q.sb_n[0];
  assign bus.sleep_request_n      = q.sb_n[1];
  assign bus.clock_stop_request_n = q.sb_n[2];
  assign bus.mgmt_interrupt_in_n  = q.sb_n[3];
  assign bus.soft_init_n          = q.sb_n[4];
  assign bus.sys_target_ready_in_o           = 1'b0;
  assign bus.sys_target_ready_in_oe_n        = ~q.target_ready_in;
  assign bus.sys_rs_o             = ~q.rs_val;
  assign bus.sys_rsp_o            = cspr_lowpar({3'h7, ~q.rs_val});
  assign bus.sys_rs_oe_n          = ~q.rs_drv;

  assign cmd_valid    = q.cmd_v;
  assign cmd          = q.cmd;
  assign cmd_perr     = q.perr;
  assign slot_state   = q.slot;
  assign test_reset_n = ~q.por;
  assign in_reset     = ~q.rst_n;

endmodule : cspr_sys
`default_nettype wire

// ---- bench/cspr_asserts.sv ----
`include "cspr_map.svh"
`default_nettype none
module cspr_asserts (
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       bus_reset_n,
  input wire logic       clock_stop_request_n,
  input wire logic       mgmt_interrupt_in_n,
  input wire logic       thermal_shutdown_out_n,
  input wire logic       dev_req_oe_n,
  input wire logic       address_strobe_n,
  input wire logic [4:0] request_cmd_n,
  input wire logic       request_parity_n,
  input wire logic [2:0] response_status_lines_n,
  input wire logic       response_parity_n,
  input wire logic       target_ready_in_n
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] STOP_ACK = `CSPR_CMD_STOP_ACK;
  localparam logic [9:0] SMI_ACK  = `CSPR_CMD_SMI_ACK;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // ----------
  // request and response groups
  // ----------
  a_req_two_cycles: assert property (
    !address_strobe_n |=> address_strobe_n && !dev_req_oe_n ##1 dev_req_oe_n)
    else $error("request not two cycles");
  a_req_parity: assert property (
    !dev_req_oe_n |-> request_parity_n == ~^(~{address_strobe_n, request_cmd_n}))
    else $error("request parity wrong");
  a_resp_parity: assert property (
    response_parity_n == ~^(~response_status_lines_n)) else $error("response parity wrong");
  a_read_resp_due: assert property (
    !address_strobe_n && request_cmd_n[0] |-> ##2 response_status_lines_n != 3'h7)
    else $error("read response missing");
  a_write_resp_due: assert property (
    !address_strobe_n && !request_cmd_n[0] |-> ##3 response_status_lines_n != 3'h7)
    else $error("write response missing");
  a_target_ready_in_on_write: assert property (
    !target_ready_in_n |-> !$past(address_strobe_n, 2) && !$past(request_cmd_n[0], 2))
    else $error("target ready without write");
  // ----------
  // reset, power states, thermal
  // ----------
  a_reset_release: assert property (
    !bus_reset_n [*3] |-> dev_req_oe_n) else $error("bus held in reset");
  a_stop_ack_sent: assert property (
    $fell(clock_stop_request_n) |-> ##[2:40] (!address_strobe_n &&
    request_cmd_n == ~STOP_ACK[4:0]) ##1 request_cmd_n == ~STOP_ACK[9:5])
    else $error("no stop acknowledge");
  a_smi_ack_sent: assert property (
    $fell(mgmt_interrupt_in_n) |-> ##[2:40] (!address_strobe_n &&
    request_cmd_n == ~SMI_ACK[4:0]) ##1 request_cmd_n == ~SMI_ACK[9:5])
    else $error("no smi acknowledge");
  a_therm_latched: assert property (
    !thermal_shutdown_out_n && bus_reset_n |=> !thermal_shutdown_out_n)
    else $error("thermal output dropped");
  a_therm_stops_bus: assert property (
    $fell(thermal_shutdown_out_n) |-> ##[0:2] dev_req_oe_n) else $error("bus kept after trip");
  c_write: cover property (!address_strobe_n && !request_cmd_n[0]);
  c_smi: cover property ($fell(mgmt_interrupt_in_n));
  c_trip: cover property ($fell(thermal_shutdown_out_n));
endmodule : cspr_asserts
`default_nettype wire

// ---- bench/cpu_sideband_power_reset_ctl_tb_top.sv ----
`include "cspr_map.svh"
`default_nettype none
module cpu_sideband_power_reset_ctl_tb_top;
  import cspr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR = 20;
  logic        mclk, srst, thermal_trip, usr_req_valid, usr_req_ready, usr_resp_valid;
  logic        usr_resp_perr, usr_wr_data_go, mgmt_exit, management_mode, save_state;
  logic        cache_invalidate, builtin_self_test_run, fetch_go, core_clk_en, bus_clk_en, snoop_en;
  logic        exec_en, intr_en, power_good_in, warm_reset_req, want_sleep, want_stop, want_smi;
  logic        want_init, cmd_valid, cmd_perr, test_reset_n, in_reset;
  logic [9:0]  usr_req_cmd, cmd;
  logic [2:0]  usr_resp_status, resp_code;
  logic [31:0] fetch_addr;
  cspr_slot_e  slot_state;
  int          n_mismatch = 0, tests_run = 0, cyc = 0, k, n;
  cspr_if bus ();
  cspr_dev u_cspr_dev (.mclk, .srst, .bus, .thermal_trip, .usr_req_valid, .usr_req_ready,
    .usr_req_cmd, .usr_resp_valid, .usr_resp_status, .usr_resp_perr, .usr_wr_data_go,
    .mgmt_exit, .management_mode, .save_state, .cache_invalidate, .builtin_self_test_run, .fetch_go,
    .fetch_addr, .core_clk_en, .bus_clk_en, .snoop_en, .intr_en, .exec_en);
  cspr_sys #(.POR_CYCLES(POR)) u_cspr_sys (.mclk, .srst, .bus, .power_good_in, .warm_reset_req,
    .scan_active(1'b0), .want_sleep, .want_stop, .want_smi, .want_init, .want_float(1'b0),
    .resp_code, .cmd_valid, .cmd, .cmd_perr, .slot_state, .test_reset_n, .in_reset);
  cspr_asserts u_cspr_asserts (.mclk, .srst, .bus_reset_n(bus.bus_reset_n),
    .clock_stop_request_n(bus.clock_stop_request_n),
    .mgmt_interrupt_in_n(bus.mgmt_interrupt_in_n),
    .thermal_shutdown_out_n(bus.thermal_shutdown_out_n), .dev_req_oe_n(bus.dev_req_oe_n),
    .address_strobe_n(bus.address_strobe_n), .request_cmd_n(bus.request_cmd_n),
    .request_parity_n(bus.request_parity_n),
    .response_status_lines_n(bus.response_status_lines_n),
    .response_parity_n(bus.response_parity_n), .target_ready_in_n(bus.target_ready_in_n));
  // ----------
  // clock, timeout and shared tasks
  // ----------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // sample at the falling edge, clear of the launch edge
  task automatic await(input string nm, ref logic s, input logic v);
    @(negedge mclk);
    for (int i = 0; i < 3000 && s !== v; i++) @(negedge mclk);
    chk(nm, v, s);
  endtask : await
  task automatic count_reset(output int cnt);
    cnt = 0;
    while (in_reset === 1'b1 && cnt < 5000) begin
      @(negedge mclk);
      cnt++;
    end
  endtask : count_reset
  task automatic warm();
    @(posedge mclk) warm_reset_req <= 1'b1;
    @(posedge mclk) warm_reset_req <= 1'b0;
    await("reset_on", in_reset, 1'b1);
  endtask : warm
  task automatic xfer(input logic [9:0] c, input logic [2:0] code);
    await("ready", usr_req_ready, 1'b1);
    @(posedge mclk) usr_req_valid <= 1'b1;
    usr_req_cmd <= c;
    resp_code <= code;
    @(posedge mclk) usr_req_valid <= 1'b0;
    await("cmd_valid", cmd_valid, 1'b1);
    chk("cmd", c, cmd);
    chk("cmd_perr", 1'b0, cmd_perr);
    if (c[0]) begin
      await("wr_go", usr_wr_data_go, 1'b1);
    end
    await("resp", usr_resp_valid, 1'b1);
    chk("status", (code == 3'h0) ? 3'h1 : code, usr_resp_status);
    chk("resp_perr", 1'b0, usr_resp_perr);
  endtask : xfer
  // ----------
  // test sequence
  // ----------
  initial begin
    {srst, thermal_trip, usr_req_valid, mgmt_exit, power_good_in, warm_reset_req} = 6'h20;
    {want_sleep, want_stop, want_smi, want_init, usr_req_cmd, resp_code} = 17'h0_0000;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    power_good_in <= 1'b1;
    @(negedge mclk);
    chk("cache_inval", 1'b1, cache_invalidate);
    chk("test_reset_n", 1'b0, test_reset_n);
    count_reset(n);
    chk("por_long", 1'b1, n > POR);
    chk("test_reset_hi", 1'b1, test_reset_n);
    await("fetch", fetch_go, 1'b1);
    chk("vector", `CSPR_RESET_VECTOR, fetch_addr);
    chk("slot", SLOT_CPU, slot_state);
    $display("test power_on done");
    for (k = 0; k < 8; k++) xfer(10'h155 ^ 10'(k * 9), 3'(k));
    $display("test transfers done");
    @(posedge mclk) want_stop <= 1'b1;
    await("stop_ack", cmd_valid, 1'b1);
    chk("stop_cmd", `CSPR_CMD_STOP_ACK, cmd);
    await("core_off", core_clk_en, 1'b0);
    chk("snoop_on", 1'b1, snoop_en);
    chk("intr_on", 1'b1, intr_en);
    @(posedge mclk) want_sleep <= 1'b1;
    await("bus_off", bus_clk_en, 1'b0);
    chk("snoop_off", 1'b0, snoop_en);
    chk("intr_off", 1'b0, intr_en);
    @(posedge mclk) want_sleep <= 1'b0;
    await("bus_on", bus_clk_en, 1'b1);
    chk("core_still_off", 1'b0, core_clk_en);
    @(posedge mclk) want_stop <= 1'b0;
    await("exec_on", exec_en, 1'b1);
    chk("core_on", 1'b1, core_clk_en);
    $display("test power_states done");
    @(posedge mclk) want_smi <= 1'b1;
    await("save", save_state, 1'b1);
    await("smi_ack", cmd_valid, 1'b1);
    chk("smi_cmd", `CSPR_CMD_SMI_ACK, cmd);
    await("mgmt_on", management_mode, 1'b1);
    @(posedge mclk) want_smi <= 1'b0;
    mgmt_exit <= 1'b1;
    @(posedge mclk) mgmt_exit <= 1'b0;
    await("mgmt_off", management_mode, 1'b0);
    $display("test smi done");
    @(posedge mclk) thermal_trip <= 1'b1;
    await("trip", bus.thermal_shutdown_out_n, 1'b0);
    chk("halted", 1'b0, exec_en);
    @(posedge mclk) thermal_trip <= 1'b0;
    repeat (20) @(negedge mclk);
    chk("trip_latched", 1'b0, bus.thermal_shutdown_out_n);
    @(posedge mclk) thermal_trip <= 1'b1;
    warm();
    count_reset(n);
    chk("warm_long", 1'b1, n > 10);
    repeat (3) @(negedge mclk);
    chk("trip_kept", 1'b0, bus.thermal_shutdown_out_n);
    @(posedge mclk) thermal_trip <= 1'b0;
    want_init <= 1'b1;
    warm();
    count_reset(n);
    await("builtin_self_test", builtin_self_test_run, 1'b1);
    await("fetch_after_builtin_self_test", fetch_go, 1'b1);
    chk("trip_gone", 1'b1, bus.thermal_shutdown_out_n);
    $display("test thermal_builtin_self_test done");
    test_done();
  end
endmodule : cpu_sideband_power_reset_ctl_tb_top
`default_nettype wire
